// ### shared/access_pkg.sv
package access_pkg;

   // ********************************************************
   // widths and depths
   // ********************************************************
   localparam int ADDR_W = 16;
   localparam int SFR_W = 8;
   localparam int SFR_DEPTH = 128;
   localparam int HW_REGS = 16;

   // ********************************************************
   // cpu modes and memory operations
   // ********************************************************
   typedef enum logic [2:0] {
      MODE_BOOT = 3'h0,
      MODE_TEST = 3'h1,
      MODE_CLOS = 3'h2,
      MODE_SYS = 3'h3,
      MODE_USER = 3'h4
   } cpu_mode_e;

   typedef enum logic [1:0] {
      OP_READ = 2'h0,
      OP_WRITE = 2'h1,
      OP_EXEC = 2'h2
   } mem_op_e;

   // rights bits of a segment entry
   localparam int SEG_RD = 0;
   localparam int SEG_WR = 1;
   localparam int SEG_EX = 2;

   // ********************************************************
   // physical memory map, last addresses inclusive
   // ********************************************************
   localparam logic [15:0] TROM_LAST = 16'h0FFF;
   localparam logic [15:0] AROM_BASE = 16'h1000;
   localparam logic [15:0] AROM_LAST = 16'h7FFF;
   localparam logic [15:0] ACM_BASE = 16'h7FC0;
   localparam logic [15:0] OSEE_BASE = 16'h8000;
   localparam logic [15:0] OSEE_LAST = 16'h8FFF;
   localparam logic [15:0] AEE_BASE = 16'h9000;
   localparam logic [15:0] AEE_LAST = 16'hBFFF;
   localparam logic [15:0] SEC_BASE = 16'hBF80;
   localparam logic [15:0] OSRAM_BASE = 16'hC000;
   localparam logic [15:0] OSRAM_LAST = 16'hC3FF;
   localparam logic [15:0] ARAM_BASE = 16'hC400;
   localparam logic [15:0] ARAM_LAST = 16'hDFFF;
   localparam logic [15:0] CRAM_BASE = 16'hE000;
   localparam logic [15:0] CRAM_LAST = 16'hE7FF;

   // ********************************************************
   // special function register map (7-bit index)
   // ********************************************************
   localparam logic [6:0] SYSM_BASE = 7'h40;
   localparam logic [6:0] SEGC_BASE = 7'h50;
   localparam logic [6:0] FWC_BASE = 7'h58;
   localparam logic [6:0] OSR_BASE = 7'h60;
   localparam logic [6:0] HW_BASE = 7'h70;
   localparam logic [6:0] STATUS_WORD_HIGH = 7'h40;
   localparam logic [6:0] SYS_POINTER_0 = 7'h41;
   localparam logic [6:0] SYS_POINTER_2 = 7'h43;
   localparam logic [6:0] SEG_PTR_LOW = 7'h50;
   localparam logic [6:0] SEG_PTR_HIGH = 7'h51;
   localparam logic [6:0] FIREWALL_CTRL_LOW = 7'h58;
   localparam logic [6:0] FIREWALL_CTRL_HIGH = 7'h59;
   localparam logic [6:0] EXCHANGE_BASE_LOW = 7'h5A;
   localparam logic [6:0] EXCHANGE_BASE_HIGH = 7'h5B;
   localparam logic [6:0] EXCHANGE_SIZE_LOW = 7'h5C;
   localparam logic [6:0] EXCHANGE_SIZE_HIGH = 7'h5D;
   localparam logic [6:0] CLOCK_SELECTION = 7'h70;
   localparam logic [6:0] RANDOM_VALUE = 7'h71;
   localparam logic [6:0] KEY_REG_A = 7'h72;
   localparam logic [6:0] KEY_REG_D = 7'h73;

   // reset values
   localparam logic [7:0] SFR_RESET = 8'h00;
   localparam logic [7:0] LFSR_SEED = 8'hA5;

   // ********************************************************
   // carriers
   // ********************************************************
   typedef struct packed {
      logic valid;
      logic src_cop;
      mem_op_e op;
      logic [15:0] addr;
   } mem_req_s;

   typedef struct packed {
      logic [2:0] rights;
      logic [15:0] hw_rights;
      logic [15:0] offset;
   } seg_entry_s;

   typedef struct packed {
      logic rd;
      logic wr;
      logic ex;
      logic deny;
      logic [15:0] addr;
   } mem_resp_s;

   typedef struct packed {
      logic [SFR_DEPTH-1:0][7:0] regs;
      logic [7:0] lfsr;
      logic [7:0] rdata;
      logic sfr_deny;
      mem_resp_s resp;
   } checker_state_s;

endpackage : access_pkg

// ### src/mem_rights.sv
`timescale 1ns/1ps
module mem_rights (
   input wire access_pkg::cpu_mode_e mode_i,
   input wire logic cop_i,
   input wire access_pkg::mem_op_e op_i,
   input wire logic [15:0] addr_i,
   input wire logic [2:0] seg_rights_i,
   input wire logic [15:0] xbase_i,
   input wire logic [15:0] xsize_i,
   output logic allow_o
);

   // ********************************************************
   // region decode on the physical address
   // ********************************************************
   logic r, w, x, rx, rw, seg_ok;
   logic in_trom, in_arom, in_acm, in_osee, in_aee, in_sec;
   logic in_osram, in_aram, in_cram, in_xwin;
   logic [15:0] xoff;

   // operation classes
   assign r = (op_i == access_pkg::OP_READ);
   assign w = (op_i == access_pkg::OP_WRITE);
   assign x = (op_i == access_pkg::OP_EXEC);
   assign rx = r | x;
   assign rw = r | w;

   // address ranges
   assign in_trom = (addr_i <= access_pkg::TROM_LAST);
   assign in_arom = (addr_i >= access_pkg::AROM_BASE) &&
                    (addr_i <= access_pkg::AROM_LAST);
   assign in_acm = (addr_i >= access_pkg::ACM_BASE) && in_arom;
   assign in_osee = (addr_i >= access_pkg::OSEE_BASE) &&
                    (addr_i <= access_pkg::OSEE_LAST);
   assign in_aee = (addr_i >= access_pkg::AEE_BASE) &&
                   (addr_i <= access_pkg::AEE_LAST);
   assign in_sec = (addr_i >= access_pkg::SEC_BASE) && in_aee;
   assign in_osram = (addr_i >= access_pkg::OSRAM_BASE) &&
                     (addr_i <= access_pkg::OSRAM_LAST);
   assign in_aram = (addr_i >= access_pkg::ARAM_BASE) &&
                    (addr_i <= access_pkg::ARAM_LAST);
   assign in_cram = (addr_i >= access_pkg::CRAM_BASE) &&
                    (addr_i <= access_pkg::CRAM_LAST);

   // exchange window; wrap-safe, the offset is only trusted above base
   assign xoff = addr_i - xbase_i;
   assign in_xwin = in_aram && (addr_i >= xbase_i) && (xoff < xsize_i);

   // the segment must carry the very right the operation needs
   assign seg_ok = (r && seg_rights_i[access_pkg::SEG_RD]) ||
                   (w && seg_rights_i[access_pkg::SEG_WR]) ||
                   (x && seg_rights_i[access_pkg::SEG_EX]);

   // ********************************************************
   // grant per mode
   // ********************************************************
   always_comb begin
      allow_o = 1'b0;
      if (cop_i) begin
         allow_o = (r && (in_osee || in_aee)) || (rw && in_cram);
      end else begin
         case (mode_i)
            access_pkg::MODE_BOOT: begin
               allow_o = (rx && in_trom) || in_osee || (rw && in_osram) ||
                         (r && in_sec);
            end
            access_pkg::MODE_TEST: begin
               allow_o = (rx && (in_trom || in_arom)) || in_osee ||
                         in_aee || (rw && (in_osram || in_aram || in_cram));
            end
            access_pkg::MODE_CLOS: begin
               allow_o = (rx && in_trom) || in_osee || (rw && in_osram) ||
                         (r && in_acm) ||
                         (rw && in_xwin) ||
                         (r && in_sec);
            end
            access_pkg::MODE_SYS: begin
               allow_o = (rx && in_arom) || in_aee || (rw && in_aram);
            end
            access_pkg::MODE_USER: begin
               allow_o = (rx && in_arom && seg_ok) ||
                         (in_aee && seg_ok) ||
                         (rw && in_aram && seg_ok);
            end
            default: begin
               allow_o = 1'b0;
            end
         endcase
      end
   end

endmodule : mem_rights

// ### src/mode_based_access_checker.sv
// Design decisions made here: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
module mode_based_access_checker (
   input wire logic core_clk_i,
   input wire logic resetn_i,
   input wire access_pkg::cpu_mode_e cpu_mode_i,
   input wire access_pkg::mem_req_s mem_req_i,
   input wire access_pkg::seg_entry_s data_seg_i,
   input wire access_pkg::seg_entry_s code_seg_i,
   input wire logic [5:0] data_seg_idx_i,
   input wire logic [7:0] sfr_addr_i,
   input wire logic [7:0] sfr_wdata_i,
   input wire logic sfr_we_i,
   input wire logic sfr_re_i,
   output logic [7:0] sfr_rdata_o,
   output logic sfr_deny_o,
   output access_pkg::mem_resp_s mem_resp_o,
   output logic [15:0] seg_table_ptr_o,
   output logic [5:0] seg_fetch_idx_o
);

   // ********************************************************
   // state
   // ********************************************************
   access_pkg::checker_state_s st;
   access_pkg::checker_state_s next_st;
   logic [5:0] seg_idx;

   // ********************************************************
   // register views
   // ********************************************************
   logic [15:0] seg_ptr;
   logic [15:0] fw_mask;
   logic [15:0] xbase;
   logic [15:0] xsize;
   logic seg_table_on;

   // pairs of byte registers seen as words, high byte first
   assign seg_ptr = {st.regs[access_pkg::SEG_PTR_HIGH],
                     st.regs[access_pkg::SEG_PTR_LOW]};
   assign fw_mask = {st.regs[access_pkg::FIREWALL_CTRL_HIGH],
                     st.regs[access_pkg::FIREWALL_CTRL_LOW]};
   assign xbase = {st.regs[access_pkg::EXCHANGE_BASE_HIGH],
                   st.regs[access_pkg::EXCHANGE_BASE_LOW]};
   assign xsize = {st.regs[access_pkg::EXCHANGE_SIZE_HIGH],
                   st.regs[access_pkg::EXCHANGE_SIZE_LOW]};

   // a zero pointer switches every segment off
   assign seg_table_on = (seg_ptr != 16'h0000);

   // ********************************************************
   // segment rights as seen by the checks
   // ********************************************************
   logic [2:0] data_rights;
   logic [15:0] code_hw_rights;

   // rights all zero already means a disabled segment
   assign data_rights = seg_table_on ? data_seg_i.rights : 3'h0;
   assign code_hw_rights = (seg_table_on &&
                            (code_seg_i.rights != 3'h0)) ?
                           code_seg_i.hw_rights : 16'h0000;

   // ********************************************************
   // address translation
   // ********************************************************
   logic [15:0] phys_addr;
   logic user_mode;

   assign user_mode = (cpu_mode_i == access_pkg::MODE_USER);

   // only user code is relocated; the others see physical space
   always_comb begin
      if (user_mode && !mem_req_i.src_cop) begin
         phys_addr = mem_req_i.addr + data_seg_i.offset;
      end else begin
         phys_addr = mem_req_i.addr;
      end
   end

   // the index of the segment in use is kept for the table walker
   assign seg_idx = data_seg_idx_i;

   // ********************************************************
   // memory permission
   // ********************************************************
   logic mem_allow;

   mem_rights u_mem_rights (
      .mode_i(cpu_mode_i),
      .cop_i(mem_req_i.src_cop),
      .op_i(mem_req_i.op),
      .addr_i(phys_addr),
      .seg_rights_i(data_rights),
      .xbase_i(xbase),
      .xsize_i(xsize),
      .allow_o(mem_allow)
   );

   // ********************************************************
   // register permission
   // ********************************************************
   // group by index; everything above the map is unmapped
   function automatic logic sfr_allow(
      input access_pkg::cpu_mode_e mode,
      input logic [7:0] addr,
      input logic wr,
      input logic [15:0] fw,
      input logic [15:0] hw
   );
      logic ok;
      logic [6:0] a;
      logic [3:0] hw_bit;
      logic sys, clos, usr;
      ok = 1'b0;
      a = addr[6:0];
      hw_bit = addr[3:0];
      sys = (mode == access_pkg::MODE_SYS);
      clos = (mode == access_pkg::MODE_CLOS);
      usr = (mode == access_pkg::MODE_USER);
      if (addr[7]) begin
         ok = 1'b0;
      end else if (a < access_pkg::SYSM_BASE) begin
         ok = 1'b1;
      end else if (mode == access_pkg::MODE_BOOT) begin
         ok = 1'b1;
      end else if (mode == access_pkg::MODE_TEST) begin
         ok = 1'b1;
      end else if (a < access_pkg::SEGC_BASE) begin
         ok = sys || (!wr && (clos || usr) &&
              (a == access_pkg::STATUS_WORD_HIGH));
      end else if (a < access_pkg::FWC_BASE) begin
         ok = sys;
      end else if (a < access_pkg::OSR_BASE) begin
         ok = sys || (clos && !wr);
      end else if (a < access_pkg::HW_BASE) begin
         ok = clos;
      end else begin
         ok = sys ||
              (clos && fw[hw_bit]) ||
              (clos && !wr && (a == access_pkg::CLOCK_SELECTION)) ||
              (usr && hw[hw_bit]);
      end
      // fixed restrictions override every mode, boot and test too
      if (!wr && (a >= access_pkg::SYS_POINTER_0) &&
          (a <= access_pkg::SYS_POINTER_2) && !addr[7]) begin
         ok = 1'b0;
      end
      if (wr && (a == access_pkg::RANDOM_VALUE) && !addr[7]) begin
         ok = 1'b0;
      end
      if (!wr && !addr[7] && ((a == access_pkg::KEY_REG_A) ||
                              (a == access_pkg::KEY_REG_D))) begin
         ok = 1'b0;
      end
      // table pointer stays out of reach of boot and test code as well
      if (!sys && !addr[7] && (a >= access_pkg::SEGC_BASE) &&
          (a < access_pkg::FWC_BASE)) begin
         ok = 1'b0;
      end
      return ok;
   endfunction : sfr_allow

   logic sfr_wr_ok;
   logic sfr_rd_ok;

   // decided in the strobe cycle so a refused write never lands
   assign sfr_wr_ok = sfr_allow(cpu_mode_i, sfr_addr_i, 1'b1,
                                fw_mask, code_hw_rights);
   assign sfr_rd_ok = sfr_allow(cpu_mode_i, sfr_addr_i, 1'b0,
                                fw_mask, code_hw_rights);

   // ********************************************************
   // read value
   // ********************************************************
   logic [7:0] sfr_value;

   // the random register has no storage, it shows the generator
   always_comb begin
      if (sfr_addr_i[6:0] == access_pkg::RANDOM_VALUE) begin
         sfr_value = st.lfsr;
      end else begin
         sfr_value = st.regs[sfr_addr_i[6:0]];
      end
   end

   // ********************************************************
   // next state
   // ********************************************************
   logic lfsr_fb;

   // taps give a maximal-length byte sequence
   assign lfsr_fb = st.lfsr[7] ^ st.lfsr[5] ^ st.lfsr[4] ^ st.lfsr[3];

   always_comb begin
      next_st = st;
      next_st.lfsr = {st.lfsr[6:0], lfsr_fb};
      next_st.rdata = 8'h00;
      next_st.sfr_deny = 1'b0;

      // register write: stored only when granted
      if (sfr_we_i) begin
         if (sfr_wr_ok) begin
            next_st.regs[sfr_addr_i[6:0]] = sfr_wdata_i;
         end else begin
            next_st.sfr_deny = 1'b1;
         end
      end

      // register read: zero when refused
      if (sfr_re_i) begin
         if (sfr_rd_ok) begin
            next_st.rdata = sfr_value;
         end else begin
            next_st.rdata = 8'h00;
            next_st.sfr_deny = 1'b1;
         end
      end

      // memory strobes only leave for granted accesses
      next_st.resp.addr = phys_addr;
      next_st.resp.rd = 1'b0;
      next_st.resp.wr = 1'b0;
      next_st.resp.ex = 1'b0;
      next_st.resp.deny = 1'b0;
      if (mem_req_i.valid) begin
         if (mem_allow) begin
            next_st.resp.rd = (mem_req_i.op == access_pkg::OP_READ);
            next_st.resp.wr = (mem_req_i.op == access_pkg::OP_WRITE);
            next_st.resp.ex = (mem_req_i.op == access_pkg::OP_EXEC);
         end else begin
            next_st.resp.deny = 1'b1;
         end
      end
   end

   // ********************************************************
   // state register
   // ********************************************************
   // all registers clear at reset, the table pointer with them; the generator loads LFSR_SEED instead
   always_ff @(posedge core_clk_i) begin
      if (!resetn_i) begin
         st <= '0;
         st.lfsr <= access_pkg::LFSR_SEED;
      end else begin
         st <= next_st;
      end
   end

   // a segment index is registered beside the response
   logic [5:0] seg_fetch_idx;

   always_ff @(posedge core_clk_i) begin
      if (!resetn_i) begin
         seg_fetch_idx <= 6'h00;
      end else begin
         seg_fetch_idx <= seg_idx;
      end
   end

   // ********************************************************
   // outputs
   // ********************************************************
   // every output is a flop of the state above
   assign sfr_rdata_o = st.rdata;
   assign sfr_deny_o = st.sfr_deny;
   assign mem_resp_o = st.resp;
   assign seg_table_ptr_o = seg_ptr;
   assign seg_fetch_idx_o = seg_fetch_idx;

endmodule : mode_based_access_checker

// ### testbench/access_checker_monitor.sv
`timescale 1ns/1ps
module access_checker_monitor (
   input wire logic core_clk_i,
   input wire logic resetn_i,
   input wire access_pkg::cpu_mode_e cpu_mode_i,
   input wire access_pkg::mem_req_s mem_req_i,
   input wire logic [7:0] sfr_addr_i,
   input wire logic sfr_we_i,
   input wire logic sfr_re_i,
   input wire logic [7:0] sfr_rdata_o,
   input wire logic sfr_deny_o,
   input wire access_pkg::mem_resp_s mem_resp_o,
   input wire logic [15:0] seg_table_ptr_o
);
   // ********************************************************
   // properties
   // ********************************************************
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!resetn_i);
   logic any_grant;
   logic seg_hit;
   // segmentation group is 0x50..0x57
   assign seg_hit = (sfr_addr_i[7:3] == 5'h0A);
   assign any_grant = mem_resp_o.rd | mem_resp_o.wr | mem_resp_o.ex;
   deny_excl_a: assert property (mem_resp_o.deny |-> !any_grant)
      else $error("deny raised beside a grant");
   resp_cause_a: assert property ((any_grant | mem_resp_o.deny)
      |-> $past(mem_req_i.valid)) else $error("response with no request");
   read_ans_a: assert property (mem_req_i.valid &&
      mem_req_i.op == access_pkg::OP_READ |=> (mem_resp_o.rd ^
      mem_resp_o.deny) && !mem_resp_o.wr && !mem_resp_o.ex)
      else $error("read answer wrong");
   write_ans_a: assert property (mem_req_i.valid &&
      mem_req_i.op == access_pkg::OP_WRITE |=> (mem_resp_o.wr ^
      mem_resp_o.deny) && !mem_resp_o.rd && !mem_resp_o.ex)
      else $error("write answer wrong");
   rdata_idle_a: assert property (!sfr_re_i |=> sfr_rdata_o == 8'h00)
      else $error("read data outside a read");
   seg_lock_a: assert property ((sfr_we_i | sfr_re_i) && seg_hit &&
      cpu_mode_i != access_pkg::MODE_SYS |=> sfr_deny_o)
      else $error("segment register reachable");
   seg_keep_a: assert property (sfr_we_i && seg_hit &&
      cpu_mode_i != access_pkg::MODE_SYS |=> $stable(seg_table_ptr_o))
      else $error("segment pointer changed");
   ptr_hidden_a: assert property (sfr_re_i &&
      sfr_addr_i inside {8'h41, 8'h42, 8'h43}
      |=> sfr_deny_o && sfr_rdata_o == 8'h00)
      else $error("system pointer readable");
   key_hidden_a: assert property (sfr_re_i &&
      sfr_addr_i inside {8'h72, 8'h73} |=> sfr_rdata_o == 8'h00)
      else $error("key register readable");
   cpu_open_a: assert property ((sfr_we_i | sfr_re_i) &&
      sfr_addr_i < 8'h40 |=> !sfr_deny_o) else $error("cpu reg denied");
   ptr_reset_a: assert property ($rose(resetn_i)
      |-> seg_table_ptr_o == 16'h0000) else $error("pointer not cleared");
   cover property (mem_resp_o.deny);
   cover property (mem_resp_o.ex);
   cover property (sfr_re_i ##1 sfr_deny_o);
endmodule : access_checker_monitor

bind mode_based_access_checker access_checker_monitor u_mon (
   .core_clk_i(core_clk_i), .resetn_i(resetn_i), .cpu_mode_i(cpu_mode_i),
   .mem_req_i(mem_req_i), .sfr_addr_i(sfr_addr_i), .sfr_we_i(sfr_we_i),
   .sfr_re_i(sfr_re_i), .sfr_rdata_o(sfr_rdata_o),
   .sfr_deny_o(sfr_deny_o), .mem_resp_o(mem_resp_o),
   .seg_table_ptr_o(seg_table_ptr_o));

// ### testbench/core_seg_model.sv
`timescale 1ns/1ps
module core_seg_model (
   input wire logic [15:0] addr_i,
   output access_pkg::seg_entry_s seg_o,
   output logic [5:0] idx_o
);
   // core side: segment entry matching the virtual address, same cycle
   always_comb begin
      seg_o = '0;
      idx_o = 6'h00;
      if (addr_i >= 16'h1000 && addr_i < 16'h4000) begin
         seg_o.rights = 3'h1;
         idx_o = 6'h01;
      end else if (addr_i >= 16'h4000 && addr_i < 16'h8000) begin
         seg_o.rights = 3'h4;
         idx_o = 6'h02;
      end else if (addr_i >= 16'h9000 && addr_i < 16'hA000) begin
         seg_o.rights = 3'h3;
         idx_o = 6'h03;
      end else if (addr_i >= 16'hA000 && addr_i < 16'hC000) begin
         idx_o = 6'h04; // no rights: segment disabled
      end else if (addr_i >= 16'hC400 && addr_i < 16'hD000) begin
         seg_o.rights = 3'h3;
         seg_o.offset = 16'h0100; // relocated window
         idx_o = 6'h05;
      end else if (addr_i >= 16'hD000 && addr_i < 16'hE000) begin
         seg_o.rights = 3'h1;
         idx_o = 6'h06;
      end
   end
endmodule : core_seg_model

// ### testbench/mode_based_access_checker_tb.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) n_checks++; if ((g) !== (e)) begin errors++; \
   $display("mismatch %s exp %0h got %0h", nm, e, g); end
module mode_based_access_checker_tb;
   localparam access_pkg::cpu_mode_e BT = access_pkg::MODE_BOOT;
   localparam access_pkg::cpu_mode_e TS = access_pkg::MODE_TEST;
   localparam access_pkg::cpu_mode_e CL = access_pkg::MODE_CLOS;
   localparam access_pkg::cpu_mode_e SY = access_pkg::MODE_SYS;
   localparam access_pkg::cpu_mode_e US = access_pkg::MODE_USER;
   localparam access_pkg::mem_op_e RD = access_pkg::OP_READ;
   localparam access_pkg::mem_op_e WR = access_pkg::OP_WRITE;
   localparam access_pkg::mem_op_e EX = access_pkg::OP_EXEC;
   logic core_clk_i, resetn_i, swe, sre, sdeny;
   access_pkg::cpu_mode_e mode;
   access_pkg::mem_req_s req;
   access_pkg::seg_entry_s dseg, cseg;
   access_pkg::mem_resp_s resp;
   logic [5:0] didx, fidx;
   logic [7:0] saddr, swd, srd;
   logic [15:0] ptr;
   int errors, n_checks, cycles;

   core_seg_model seg_model (.addr_i(req.addr), .seg_o(dseg),
      .idx_o(didx));
   mode_based_access_checker DUT (.core_clk_i(core_clk_i),
      .resetn_i(resetn_i), .cpu_mode_i(mode), .mem_req_i(req),
      .data_seg_i(dseg), .code_seg_i(cseg), .data_seg_idx_i(didx),
      .sfr_addr_i(saddr), .sfr_wdata_i(swd), .sfr_we_i(swe),
      .sfr_re_i(sre), .sfr_rdata_o(srd), .sfr_deny_o(sdeny),
      .mem_resp_o(resp), .seg_table_ptr_o(ptr), .seg_fetch_idx_o(fidx));

   initial begin
      core_clk_i = 1'b0;
      forever #5 core_clk_i = ~core_clk_i;
   end

   // hang guard: the whole sequence needs well under 1000 cycles
   always @(posedge core_clk_i) begin
      cycles++;
      if (cycles == 2000) begin
         errors++;
         report_and_stop();
      end
   end

   task automatic report_and_stop();
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : report_and_stop

   // one-cycle register write, deny flag looked at in the answer cycle
   task automatic sw(input access_pkg::cpu_mode_e m, input logic [7:0] a,
                     input logic [7:0] d, input logic dn);
      @(posedge core_clk_i);
      mode <= m;
      saddr <= a;
      swd <= d;
      swe <= 1'b1;
      @(posedge core_clk_i);
      swe <= 1'b0;
      #1;
      `CHK("wdeny", dn, sdeny)
   endtask : sw

   task automatic sr(input access_pkg::cpu_mode_e m, input logic [7:0] a,
                     input logic [7:0] e, input logic dn);
      @(posedge core_clk_i);
      mode <= m;
      saddr <= a;
      sre <= 1'b1;
      @(posedge core_clk_i);
      sre <= 1'b0;
      #1;
      `CHK("rdata", e, srd)
      `CHK("rdeny", dn, sdeny)
   endtask : sr

   // memory request; a grant must echo the operation, a refusal only deny
   task automatic mc(input access_pkg::cpu_mode_e m, input logic c,
                     input access_pkg::mem_op_e o, input logic [15:0] a,
                     input logic ok);
      logic [3:0] e;
      e = ok ? {o == RD, o == WR, o == EX, 1'b0} : 4'h1;
      @(posedge core_clk_i);
      mode <= m;
      req <= '{valid: 1'b1, src_cop: c, op: o, addr: a};
      @(posedge core_clk_i);
      req.valid <= 1'b0;
      #1;
      `CHK("resp", e, {resp.rd, resp.wr, resp.ex, resp.deny})
   endtask : mc

   initial begin
      resetn_i = 1'b0;
      mode = BT;
      req = '0;
      cseg = '0;
      saddr = 8'h00;
      swd = 8'h00;
      swe = 1'b0;
      sre = 1'b0;
      errors = 0;
      n_checks = 0;
      cycles = 0;
      repeat (3) @(posedge core_clk_i);
      resetn_i <= 1'b1;
      @(posedge core_clk_i);
      #1;
      `CHK("ptr", 16'h0000, ptr)
      mc(US, 1'b0, RD, 16'h2000, 1'b0);
      // ********************************************************
      // register groups per mode
      // ********************************************************
      sw(BT, 8'h10, 8'h3C, 1'b0);
      for (int i = 0; i < 5; i++)
         sr(access_pkg::cpu_mode_e'(i), 8'h10, 8'h3C, 1'b0);
      sw(TS, 8'h60, 8'h77, 1'b0);
      sr(TS, 8'h60, 8'h77, 1'b0);
      sw(CL, 8'h61, 8'h11, 1'b0);
      sr(CL, 8'h61, 8'h11, 1'b0);
      sw(BT, 8'h40, 8'h5A, 1'b0);
      sr(CL, 8'h40, 8'h5A, 1'b0);
      sr(US, 8'h40, 8'h5A, 1'b0);
      sw(US, 8'h40, 8'h00, 1'b1);
      sr(SY, 8'h40, 8'h5A, 1'b0);
      sw(SY, 8'h50, 8'h12, 1'b0);
      sw(SY, 8'h51, 8'h34, 1'b0);
      `CHK("ptr", 16'h3412, ptr)
      sw(US, 8'h50, 8'hFF, 1'b1);
      sw(CL, 8'h51, 8'hFF, 1'b1);
      sw(BT, 8'h50, 8'hFF, 1'b1);
      sr(TS, 8'h51, 8'h00, 1'b1);
      sr(US, 8'h50, 8'h00, 1'b1);
      `CHK("ptr", 16'h3412, ptr)
      sr(BT, 8'h41, 8'h00, 1'b1);
      sr(SY, 8'h43, 8'h00, 1'b1);
      sr(SY, 8'h72, 8'h00, 1'b1);
      sr(BT, 8'h73, 8'h00, 1'b1);
      sw(SY, 8'h71, 8'h55, 1'b1);
      sr(BT, 8'h80, 8'h00, 1'b1);
      // firewall bit 4 opens hardware register 0x74
      sw(SY, 8'h59, 8'h00, 1'b0);
      sw(SY, 8'h58, 8'h10, 1'b0);
      sr(CL, 8'h58, 8'h10, 1'b0);
      sw(CL, 8'h58, 8'hFF, 1'b1);
      sw(CL, 8'h74, 8'h66, 1'b0);
      sr(CL, 8'h74, 8'h66, 1'b0);
      sw(SY, 8'h58, 8'h00, 1'b0);
      sw(CL, 8'h74, 8'h99, 1'b1);
      sr(CL, 8'h74, 8'h00, 1'b1);
      sw(SY, 8'h70, 8'h3A, 1'b0);
      sr(CL, 8'h70, 8'h3A, 1'b0);
      cseg <= '{rights: 3'h4, hw_rights: 16'h0010, offset: 16'h0000};
      sr(US, 8'h74, 8'h66, 1'b0);
      cseg.hw_rights <= 16'h0000;
      sw(US, 8'h74, 8'h12, 1'b1);
      sr(US, 8'h74, 8'h00, 1'b1);
      // exchange window 0xC800..0xC8FF
      sw(SY, 8'h5A, 8'h00, 1'b0);
      sw(SY, 8'h5B, 8'hC8, 1'b0);
      sw(SY, 8'h5C, 8'h00, 1'b0);
      sw(SY, 8'h5D, 8'h01, 1'b0);
      // ********************************************************
      // memory rights
      // ********************************************************
      mc(CL, 1'b0, EX, 16'h0100, 1'b1);
      mc(CL, 1'b0, WR, 16'h0100, 1'b0);
      mc(CL, 1'b0, WR, 16'h8100, 1'b1);
      mc(CL, 1'b0, EX, 16'h8FFF, 1'b1);
      mc(CL, 1'b0, WR, 16'hC000, 1'b1);
      mc(CL, 1'b0, EX, 16'hC000, 1'b0);
      mc(CL, 1'b0, RD, 16'h2000, 1'b0);
      mc(SY, 1'b0, RD, 16'h2000, 1'b1);
      mc(SY, 1'b0, EX, 16'h7000, 1'b1);
      mc(SY, 1'b0, WR, 16'h7000, 1'b0);
      mc(SY, 1'b0, WR, 16'h9500, 1'b1);
      mc(SY, 1'b0, WR, 16'hC800, 1'b1);
      mc(SY, 1'b0, EX, 16'hC800, 1'b0);
      mc(SY, 1'b0, RD, 16'h8100, 1'b0);
      mc(US, 1'b0, RD, 16'h2000, 1'b1);
      `CHK("idx", 6'h01, fidx)
      mc(US, 1'b0, EX, 16'h2000, 1'b0);
      mc(US, 1'b0, EX, 16'h5000, 1'b1);
      mc(US, 1'b0, WR, 16'h9500, 1'b1);
      mc(US, 1'b0, EX, 16'h9500, 1'b0);
      mc(US, 1'b0, RD, 16'hA100, 1'b0);
      mc(US, 1'b0, WR, 16'hC400, 1'b1);
      `CHK("phys", 16'hC500, resp.addr)
      mc(US, 1'b0, RD, 16'hD100, 1'b1);
      mc(US, 1'b0, WR, 16'hD100, 1'b0);
      mc(CL, 1'b0, RD, 16'h7FC0, 1'b1);
      mc(CL, 1'b0, RD, 16'h7FBF, 1'b0);
      mc(CL, 1'b0, RD, 16'hC800, 1'b1);
      mc(CL, 1'b0, RD, 16'hC8FF, 1'b1);
      mc(CL, 1'b0, RD, 16'hC900, 1'b0);
      mc(CL, 1'b0, RD, 16'hBF80, 1'b1);
      mc(BT, 1'b0, RD, 16'hBFFF, 1'b1);
      mc(CL, 1'b0, RD, 16'hBF7F, 1'b0);
      mc(SY, 1'b1, RD, 16'h9000, 1'b1);
      mc(SY, 1'b1, WR, 16'h9000, 1'b0);
      mc(SY, 1'b1, WR, 16'hE000, 1'b1);
      mc(US, 1'b1, RD, 16'hE7FF, 1'b1);
      report_and_stop();
   end
endmodule : mode_based_access_checker_tb
